// ===== pkg/mpc_pkg.sv
package mpc_pkg;
    // Register placement and reset value
    localparam logic [7:0] MPC_MISC_CFG_OFFSET = 8'hf0;
    localparam logic [31:0] MPC_MISC_CFG_RESET = 32'h0000_2400;
    // Mask of bits that software may write; bits 9 to 5 are all reserved
    localparam logic [31:0] MPC_MISC_CFG_WMASK = 32'h0000_a41f;
    // Field positions
    localparam int MPC_BIT_COLD_WAKE = 15;
    localparam int MPC_BIT_WAKE_D2 = 13;
    localparam int MPC_BIT_D2_SUP = 10;
    localparam int MPC_BIT_ABORT_SUPP = 4;
    localparam int MPC_BIT_TWO_WIRE = 3;
    localparam int MPC_BIT_LINK_BYP = 2;
    localparam int MPC_BIT_HOST_BYP = 1;
    localparam int MPC_BIT_KEEP_CLK = 0;
    // All-ones data returned instead of an abort
    localparam logic [31:0] MPC_ALL_ONES = 32'hffff_ffff;
    // Values after reset of the answer and pin flops
    localparam logic [31:0] MPC_DATA_RESET = 32'h0000_0000;
    localparam logic [1:0] MPC_PIN_OE_N_RESET = 2'h3;
    localparam logic [1:0] MPC_PIN_OUT_RESET = 2'h3;
    localparam logic [1:0] MPC_TWO_WIRE_IDLE = 2'h3;

    // Configuration access request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } mpc_cfg_req_t;

    // Power management capability bits presented by this register
    typedef struct packed {
        logic cold_wake_capable;
        logic wake_from_low_state_capable;
        logic low_state_supported;
    } mpc_pm_cap_t;
endpackage : mpc_pkg

// ===== src/mpc_misc_cfg.sv
// Functional notes
// - Bits 31 to 16 always read zero.
// - Bits 14, 12-11 and 9-5 read zero and are read-only.
// - Writable bit 15 drives the cold-wake capability bit.
// - Writable bit 13 drives the wake-from-D2 capability bit.
// - Writable bit 10 drives the Low_state_supported capability bit.
// - Abort-suppression bit 4 resets to zero: normal target abort.
// - Suppression on, link clock stopped: link reads complete with all ones.
// - Suppression off: link access with link clock stopped gets target abort.
// - Bit 3 routes pin three to serial clock, pin two to data.
// - While routed, both general pin drivers are released.
// - Bit 2 bypasses link clock gating.
// - Bit 1 bypasses host clock gating.
// - Bit 0 asks clock-run protocol to keep host clock running.
// - Bit 0 clear lets the system stop the host clock.
// - Register sits at offset f0 and resets to 0000 2400.
`timescale 1ns/1ns
`default_nettype none
module mpc_misc_cfg
    import mpc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    // Configuration access
    input wire mpc_cfg_req_t cfg_req_in,
    output logic [31:0] cfg_rdata_out,
    output logic cfg_rvalid_out,
    // Link-domain register access from host
    input wire logic link_access_in,
    input wire logic link_clock_running_in,
    input wire logic [31:0] link_rdata_in,
    output logic [31:0] link_rdata_out,
    output logic link_done_out,
    output logic target_abort_out,
    // Settings presented to the rest of the device
    output mpc_pm_cap_t pm_cap_out,
    output logic link_clock_gate_bypass_out,
    output logic host_clock_gate_bypass_out,
    output logic keep_clock_request_out,
    // General pins and two-wire bus
    input wire logic gp3_out_in,
    input wire logic gp2_out_in,
    input wire logic gp3_oe_n_in,
    input wire logic gp2_oe_n_in,
    input wire logic general_pin_three_in,
    input wire logic general_pin_two_in,
    output logic general_pin_three_out,
    output logic general_pin_two_out,
    output logic general_pin_three_oe_n_out,
    output logic general_pin_two_oe_n_out,
    output logic two_wire_clock_out,
    output logic two_wire_data_out
);

    // Limitations worth knowing:
    // - Only one register lives here; writes to every other offset are ignored.
    // - The bypass bits are test hooks; here they only present levels.
    // - Bit 4 decides at the access edge, so a write to it counts from the next cycle.
    // - Two-wire levels are sampled, so they trail the pins by one cycle.
    // - A read of another offset still pulses valid, with zero data.
    // - Reserved bits are masked on write and on read, so no path sets them.
    // - The host must not rely on the all-ones answer while bit 4 is zero.

    // Stored word and its next value; only writable bits ever hold a one
    logic [31:0] misc_q;
    logic [31:0] misc_d;

    // Read answer, held in flops so the bus sees settled data
    logic [31:0] cfg_rdata_q;
    logic [31:0] cfg_rdata_d;
    logic cfg_rvalid_q;
    logic cfg_rvalid_d;

    // Link answer flops
    logic [31:0] link_rdata_q;
    logic [31:0] link_rdata_d;
    logic link_done_q;
    logic link_done_d;
    logic abort_q;
    logic abort_d;

    // Pin flops: index 1 is pin three, index 0 is pin two
    logic [1:0] gp_oe_n_q;
    logic [1:0] gp_oe_n_d;
    logic [1:0] gp_out_q;
    logic [1:0] gp_out_d;

    // Two-wire flops: index 1 is the clock line, index 0 the data line
    logic [1:0] tw_q;
    logic [1:0] tw_d;

    // Offset decode, shared by the write path and the read path
    function automatic logic is_misc_offset(input logic [7:0] addr);
        is_misc_offset = (addr == MPC_MISC_CFG_OFFSET);
    endfunction : is_misc_offset

    // Request decode; any other offset is simply not ours
    wire logic wr_hit;
    wire logic rd_hit;
    assign wr_hit = cfg_req_in.wr && is_misc_offset(cfg_req_in.addr);
    assign rd_hit = cfg_req_in.rd && is_misc_offset(cfg_req_in.addr);

    // Byte-lane expansion: each enable guards its own eight bits
    wire logic [31:0] lane_en;
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign lane_en[lane*8 +: 8] = {8{cfg_req_in.be[lane]}};
        end
    endgenerate

    // Reserved bits never take data, whatever the enables say
    wire logic [31:0] wmask;
    assign wmask = lane_en & MPC_MISC_CFG_WMASK;

    // Merge the enabled lanes into the stored word
    wire logic [31:0] merged;
    assign merged = (misc_q & ~wmask) | (cfg_req_in.wdata & wmask);
    // A write and a read at the same edge: the read still gets the old word
    assign misc_d = wr_hit ? merged : misc_q;

    // Bit map of the stored word
    //   bit   meaning
    //   31-16 reserved, read zero
    //   15    cold-wake capability preset
    //   14    reserved
    //   13    wake-from-D2 capability preset
    //   12-11 reserved
    //   10    Low_state_supported preset
    //   9-5   reserved
    //   4     abort suppression
    //   3     general pins to two-wire bus
    //   2     link clock gate bypass
    //   1     host clock gate bypass
    //   0     keep host clock running
    // After reset only bits 13 and 10 are set.

    // Field views of the stored word
    wire logic cold_wake_bit;
    wire logic wake_d2_bit;
    wire logic d2_sup_bit;
    wire logic suppress;
    wire logic routed;
    wire logic link_byp_bit;
    wire logic host_byp_bit;
    wire logic keep_clk_bit;

    // Capability presets
    assign cold_wake_bit = misc_q[MPC_BIT_COLD_WAKE];
    assign wake_d2_bit = misc_q[MPC_BIT_WAKE_D2];
    assign d2_sup_bit = misc_q[MPC_BIT_D2_SUP];
    // Control bits
    assign suppress = misc_q[MPC_BIT_ABORT_SUPP];
    assign routed = misc_q[MPC_BIT_TWO_WIRE];
    assign link_byp_bit = misc_q[MPC_BIT_LINK_BYP];
    assign host_byp_bit = misc_q[MPC_BIT_HOST_BYP];
    assign keep_clk_bit = misc_q[MPC_BIT_KEEP_CLK];

    // Read data; reserved bits are masked again so they can only read zero
    assign cfg_rdata_d = rd_hit ? (misc_q & MPC_MISC_CFG_WMASK) : MPC_DATA_RESET;
    // Every read gets a valid pulse; a miss answers zero
    assign cfg_rvalid_d = cfg_req_in.rd;

    // Link access while its clock is stopped
    wire logic link_stopped;
    assign link_stopped = link_access_in && !link_clock_running_in;

    // Stopped link either aborts or completes, never both; data is all ones either way
    assign abort_d = link_stopped && !suppress;
    assign link_done_d = link_access_in && !abort_d;

    // Data bus carries all ones on a stopped link, zero when idle
    wire logic [31:0] link_data_sel;
    assign link_data_sel = link_stopped ? MPC_ALL_ONES : link_rdata_in;
    assign link_rdata_d = link_access_in ? link_data_sel : MPC_DATA_RESET;

    // Routed pins are released; enables are active low
    assign gp_oe_n_d[1] = routed | gp3_oe_n_in;
    assign gp_oe_n_d[0] = routed | gp2_oe_n_in;
    // Output levels still follow the rest of the chip, unseen while released
    assign gp_out_d[1] = gp3_out_in;
    assign gp_out_d[0] = gp2_out_in;
    // Two-wire lines see the pin levels when routed and float high otherwise
    assign tw_d[1] = routed ? general_pin_three_in : 1'b1;
    assign tw_d[0] = routed ? general_pin_two_in : 1'b1;

    // Register itself; reset gives conventional abort and D2 advertised
    // Masking again on load keeps reserved bits zero even if a lane slips
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            misc_q <= MPC_MISC_CFG_RESET;
        end else begin
            misc_q <= misc_d & MPC_MISC_CFG_WMASK;
        end
    end

    // Read data flop
    // Cleared between reads so stale data never looks like an answer
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_rdata_q <= MPC_DATA_RESET;
        end else begin
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    // Read valid flop
    // One pulse per read, hit or miss, so the host never waits forever
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cfg_rvalid_q <= 1'b0;
        end else begin
            cfg_rvalid_q <= cfg_rvalid_d;
        end
    end

    // Link data flop
    // Zero while idle, so a late sampler cannot mistake old data
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_rdata_q <= MPC_DATA_RESET;
        end else begin
            link_rdata_q <= link_rdata_d;
        end
    end

    // Link completion flop
    // Covers the all-ones answer too, since that access completes
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            link_done_q <= 1'b0;
        end else begin
            link_done_q <= link_done_d;
        end
    end

    // Target abort flop
    // Never set together with done, so the host sees one outcome
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            abort_q <= 1'b0;
        end else begin
            abort_q <= abort_d;
        end
    end

    // Pin enable flops, active low
    // Reset releases both pins until the settings are known
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gp_oe_n_q <= MPC_PIN_OE_N_RESET;
        end else begin
            gp_oe_n_q <= gp_oe_n_d;
        end
    end

    // Pin level flops
    // Reset shows the released level so nothing toggles at start
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            gp_out_q <= MPC_PIN_OUT_RESET;
        end else begin
            gp_out_q <= gp_out_d;
        end
    end

    // Two-wire level flops
    // Idle high like a pulled-up bus line when not routed
    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tw_q <= MPC_TWO_WIRE_IDLE;
        end else begin
            tw_q <= tw_d;
        end
    end

    // Outputs come straight from the flops above
    assign cfg_rdata_out = cfg_rdata_q;
    assign cfg_rvalid_out = cfg_rvalid_q;
    assign link_rdata_out = link_rdata_q;
    assign link_done_out = link_done_q;
    assign target_abort_out = abort_q;

    // Settings are levels of the stored word, itself a flop
    assign pm_cap_out.cold_wake_capable = cold_wake_bit;
    assign pm_cap_out.wake_from_low_state_capable = wake_d2_bit;
    assign pm_cap_out.low_state_supported = d2_sup_bit;
    assign link_clock_gate_bypass_out = link_byp_bit;
    assign host_clock_gate_bypass_out = host_byp_bit;

    // Zero here lets clock-run stop the host clock
    assign keep_clock_request_out = keep_clk_bit;

    // Pin and two-wire levels
    assign general_pin_three_out = gp_out_q[1];
    assign general_pin_two_out = gp_out_q[0];
    assign general_pin_three_oe_n_out = gp_oe_n_q[1];
    assign general_pin_two_oe_n_out = gp_oe_n_q[0];
    assign two_wire_clock_out = tw_q[1];
    assign two_wire_data_out = tw_q[0];
endmodule : mpc_misc_cfg
`default_nettype wire

// ===== testbench/mpc_misc_cfg_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_misc_cfg_checker import mpc_pkg::*; (
    input wire logic sys_clk_in, rstn_in, link_access_in, link_clock_running_in, gp3_out_in,
    input wire mpc_cfg_req_t cfg_req_in,
    input wire logic [31:0] cfg_rdata_out, link_rdata_in, link_rdata_out,
    input wire logic cfg_rvalid_out, link_done_out, target_abort_out, general_pin_three_out,
    input wire logic general_pin_three_oe_n_out, two_wire_clock_out, two_wire_data_out,
    input wire mpc_pm_cap_t pm_cap_out
);
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_rsv; cfg_rvalid_out |-> (cfg_rdata_out & ~MPC_MISC_CFG_WMASK) == 32'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits set");
    property p_rv; cfg_req_in.rd |=> cfg_rvalid_out; endproperty
    a_rv: assert property (p_rv) else $error("no read answer");
    property p_cap; cfg_rvalid_out && $past(!cfg_req_in.wr && cfg_req_in.addr == 8'hf0)
        |-> {cfg_rdata_out[15], cfg_rdata_out[13], cfg_rdata_out[10]} == pm_cap_out; endproperty
    a_cap: assert property (p_cap) else $error("capability bits differ");
    property p_oth; cfg_req_in.wr && cfg_req_in.addr != 8'hf0 |=> $stable(pm_cap_out); endproperty
    a_oth: assert property (p_oth) else $error("foreign write landed");
    property p_stop; link_access_in && !link_clock_running_in |=>
        (link_done_out != target_abort_out) && link_rdata_out == MPC_ALL_ONES; endproperty
    a_stop: assert property (p_stop) else $error("stopped link answer");
    property p_run; link_access_in && link_clock_running_in |=> link_done_out &&
        !target_abort_out && link_rdata_out == $past(link_rdata_in); endproperty
    a_run: assert property (p_run) else $error("running link answer");
    property p_idle; !link_access_in |=> !link_done_out && !target_abort_out; endproperty
    a_idle: assert property (p_idle) else $error("spurious link answer");
    property p_wire; !general_pin_three_oe_n_out |-> two_wire_clock_out && two_wire_data_out;
    endproperty
    a_wire: assert property (p_wire) else $error("pin driven while routed");
    property p_pin; $rose(gp3_out_in) |=> general_pin_three_out; endproperty
    a_pin: assert property (p_pin) else $error("pin copy late");
    c_abort: cover property (target_abort_out);
    c_ones: cover property (link_done_out && link_rdata_out == MPC_ALL_ONES);
    c_route: cover property (general_pin_three_oe_n_out && !two_wire_clock_out);
endmodule : mpc_misc_cfg_checker
bind mpc_misc_cfg mpc_misc_cfg_checker u_chk (.*);
`default_nettype wire

// ===== testbench/mpc_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module mpc_host_model import mpc_pkg::*; (
    input wire logic sys_clk_in,
    input wire logic [31:0] cfg_rdata_out,
    output mpc_cfg_req_t cfg_req_in
);
    initial cfg_req_in = '0;
    // One config cycle; idle bus shows inverted fields so stale data never passes
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        acc_be(w, a, d, 4'hf, q);
    endtask : acc
    // Same cycle with a chosen set of byte lanes
    task automatic acc_be(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] be, output logic [31:0] q);
        @(posedge sys_clk_in) cfg_req_in <= '{w, !w, a, be, d};
        @(posedge sys_clk_in) cfg_req_in <= '{1'b0, 1'b0, ~a, 4'h0, ~d};
        #1 q = cfg_rdata_out;
    endtask : acc_be
endmodule : mpc_host_model
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic sys_clk_in = 0, rstn_in = 0, link_access_in = 0, link_clock_running_in = 1;
    logic gp3_out_in = 0, gp2_out_in = 0, gp3_oe_n_in = 0, gp2_oe_n_in = 0;
    logic general_pin_three_in = 1, general_pin_two_in = 1;
    logic [31:0] link_rdata_in = 32'h1234_5678, cfg_rdata_out, link_rdata_out, q;
    logic cfg_rvalid_out, link_done_out, target_abort_out, link_clock_gate_bypass_out;
    logic host_clock_gate_bypass_out, keep_clock_request_out, general_pin_three_out;
    logic general_pin_two_out, general_pin_three_oe_n_out, general_pin_two_oe_n_out;
    logic two_wire_clock_out, two_wire_data_out;
    mpc_pkg::mpc_cfg_req_t cfg_req_in;
    mpc_pkg::mpc_pm_cap_t pm_cap_out;
    int n_mismatch = 0, checked = 0, cyc = 0;
    mpc_misc_cfg DUT (.*);
    mpc_host_model host (.*);
    // Clock and a hang guard well above the forty or so cycles needed
    always #25 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) if (++cyc == 3000) begin n_mismatch++; stop_test(); end
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end
    endtask : chk
    task automatic link_acc(logic run);
        @(posedge sys_clk_in) begin link_access_in <= 1; link_clock_running_in <= run; end
        @(posedge sys_clk_in) link_access_in <= 0;
        #1;
    endtask : link_acc
    task automatic t_reset;
        host.acc(0, 8'hf0, 0, q);
        chk("reset", 32'h0000_2400, q);
        chk("cap", 3'b011, pm_cap_out);
        chk("gate", 0, {link_clock_gate_bypass_out, host_clock_gate_bypass_out});
        chk("keep", 0, keep_clock_request_out);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_link;
        link_acc(1);
        chk("run", 32'h1234_5678, link_rdata_out);
        link_acc(0);
        chk("abort", 2'b01, {link_done_out, target_abort_out});
        host.acc(1, 8'hf0, 32'h10, q);
        link_acc(0);
        chk("ones", 32'hffff_ffff, link_rdata_out);
        chk("supp", 2'b10, {link_done_out, target_abort_out});
        $display("t_link done");
    endtask : t_link
    task automatic t_regs;
        host.acc(1, 8'hf0, '1, q);
        host.acc(1, 8'hf4, 0, q);
        host.acc(0, 8'hf0, 0, q);
        chk("ones", 32'h0000_a41f, q);
        chk("cap", 3'b111, pm_cap_out);
        chk("byp", 3'b111, {link_clock_gate_bypass_out, host_clock_gate_bypass_out,
            keep_clock_request_out});
        host.acc_be(1, 8'hf0, 0, 4'he, q);
        host.acc(0, 8'hf0, 0, q);
        chk("lane", 32'h0000_001f, q);
        host.acc(1, 8'hf0, 0, q);
        chk("clr", 3'b000, pm_cap_out);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_pins;
        @(posedge sys_clk_in) gp3_out_in <= 1;
        repeat (2) @(posedge sys_clk_in);
        #1 chk("norm", 5'b10011, {general_pin_three_out, general_pin_two_out, general_pin_three_oe_n_out,
            two_wire_clock_out, two_wire_data_out});
        @(posedge sys_clk_in) general_pin_three_in <= 0;
        host.acc(1, 8'hf0, 32'h8, q);
        repeat (2) @(posedge sys_clk_in);
        #1 chk("route", 4'b1101, {general_pin_three_oe_n_out, general_pin_two_oe_n_out,
            two_wire_clock_out, two_wire_data_out});
        $display("t_pins done");
    endtask : t_pins
    task automatic stop_test;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : stop_test
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rstn_in <= 1;
        t_reset(); t_link(); t_regs(); t_pins();
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
